// file: hw/sop_pkg.sv
// package for the synchronous otp pin-mode and command logic
// assumes a single 200 MHz clock domain
package sop_pkg;
    localparam int ROW_W = 13;
    localparam int COL_W = 9;
    localparam int DQ_W = 32;
    localparam int DQ_LO_W = 16;
    localparam int BURST_W = 4;
    localparam int LAT_W = 3;
    localparam int MRS_BLOCK = 3;
    localparam logic [BURST_W-1:0] BURST_LEN_RST = 4'h8;
    localparam logic [LAT_W-1:0] CAS_LAT_RST = 3'h5;
    localparam logic [DQ_W-1:0] DATA_RST = 32'h0000_0000;
    localparam logic [1:0] MASK_DELAY = 2'h2;

    typedef enum logic [1:0] {
        SOP_CMD_NOP = 2'b00,
        SOP_CMD_MRS = 2'b01,
        SOP_CMD_ACT = 2'b10,
        SOP_CMD_RD = 2'b11
    } sop_cmd_e;

    typedef enum logic [1:0] {
        SOP_ST_IDLE = 2'b00,
        SOP_ST_READ = 2'b01,
        SOP_ST_SUSP = 2'b10,
        SOP_ST_PDN = 2'b11
    } sop_state_e;

    // synchronous command pins, all sampled on clk
    typedef struct packed {
        logic cke;
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic mode_strobe_n;
    } sop_cmd_s;

    // programming-side pins
    typedef struct packed {
        logic addr_mux_select;
        logic ras_n;
        logic cas_n;
        logic ce_n;
        logic oe_n;
    } sop_prog_s;
endpackage

// file: hw/sop_decode.sv
// synchronous command decoder, registered one cycle
// assumes the command pins are synchronous to clk
`timescale 1ns/1ps
module sop_decode (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // pins
    input wire sop_pkg::sop_cmd_s pins,
    // decoded
    output sop_pkg::sop_cmd_e cmd,
    output logic stop,
    output logic cke_prev
);
    import sop_pkg::*;
    sop_cmd_e cmd_d;
    logic stop_d;

    always_comb begin
        cmd_d = SOP_CMD_NOP;
        stop_d = 1'b0;
        if (pins.cke && !pins.cs_n) begin
            unique case ({pins.ras_n, pins.cas_n, pins.mode_strobe_n})
                3'b000: cmd_d = SOP_CMD_MRS;
                3'b011: cmd_d = SOP_CMD_ACT;
                3'b101: cmd_d = SOP_CMD_RD;
                3'b110, 3'b010: stop_d = 1'b1;
                default: cmd_d = SOP_CMD_NOP;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cmd <= SOP_CMD_NOP;
            stop <= 1'b0;
            cke_prev <= 1'b1;
        end else begin
            cmd <= cmd_d;
            stop <= stop_d;
            cke_prev <= pins.cke;
        end
    end
endmodule // sop_decode

// file: hw/sop_prog_addr.sv
// programming address capture: parallel or row/column multiplexed
// assumes strobes are slow compared with clk and synchronous to it
`timescale 1ns/1ps
module sop_prog_addr (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // pins
    input wire logic enable,
    input wire sop_pkg::sop_prog_s prog,
    input wire logic [sop_pkg::ROW_W-1:0] addr,
    input wire logic [sop_pkg::COL_W-1:0] column_addr_pins,
    // captured address
    output logic [sop_pkg::ROW_W-1:0] row_q,
    output logic [sop_pkg::COL_W-1:0] col_q
);
    import sop_pkg::*;
    logic ras_prev_q, cas_prev_q, ras_prev_d, cas_prev_d;
    logic [ROW_W-1:0] row_d;
    logic [COL_W-1:0] col_d;

    always_comb begin
        ras_prev_d = prog.ras_n;
        cas_prev_d = prog.cas_n;
        row_d = row_q;
        col_d = col_q;
        if (enable) begin
            if (!prog.addr_mux_select) begin
                // strobes ignored, column pins used
                row_d = addr;
                col_d = column_addr_pins;
            end else begin
                // column pins ignored
                if (prog.ras_n && !ras_prev_q)
                    row_d = addr;
                if (prog.cas_n && !cas_prev_q)
                    col_d = addr[COL_W-1:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ras_prev_q <= 1'b1;
            cas_prev_q <= 1'b1;
            row_q <= '0;
            col_q <= '0;
        end else begin
            ras_prev_q <= ras_prev_d;
            cas_prev_q <= cas_prev_d;
            row_q <= row_d;
            col_q <= col_d;
        end
    end

    a_mux_row_cap: assert property (@(posedge clk) disable iff (!rst_n)
        enable && prog.addr_mux_select && prog.ras_n && !ras_prev_q
        |=> row_q == $past(addr)) else $error("row not captured");
    a_par_col: assert property (@(posedge clk) disable iff (!rst_n)
        enable && !prog.addr_mux_select
        |=> col_q == $past(column_addr_pins))
        else $error("parallel column lost");
endmodule // sop_prog_addr

// file: hw/sop_top.sv
// pin-mode select and synchronous burst-read command logic of an otp
// assumes all pins synchronous to clk; array data arrives on array_data
`timescale 1ns/1ps

// Functional notes
// - static_select high means programming, else synchronous
// - unmuxed programming takes row and column together
// - muxed programming shares A0..A12 for row, A0..A8 for column
// - row captured on row strobe rise
// - column captured on column strobe rise
// - strobes ignored when mux select low
// - column pins ignored when mux select high
// - data lines in for program, out verify/read
// - width select high x32, low x16 in sync reads; verify always x16
// - column pins never driven in x16
// - chip/output enable strobe programming cycles
// - read command latches column, starts burst
// - stop ends burst after column latency
// - cke freezes internal clock next edge
// - row address kept across power down
module sop_top #(
    parameter int BURST_LEN = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // mode pins
    input wire logic static_select,
    input wire logic word_wide,
    // synchronous command pins
    input wire sop_pkg::sop_cmd_s cmd_pins,
    input wire logic out_mask,
    input wire logic [sop_pkg::ROW_W-1:0] addr,
    // programming pins
    input wire sop_pkg::sop_prog_s prog_pins,
    input wire logic [sop_pkg::COL_W-1:0] column_addr_pins,
    input wire logic [sop_pkg::DQ_LO_W-1:0] dq_in,
    // array side
    input wire logic [sop_pkg::DQ_W-1:0] array_data,
    output logic [sop_pkg::ROW_W-1:0] row_addr,
    output logic [sop_pkg::COL_W-1:0] col_addr,
    output logic [sop_pkg::DQ_LO_W-1:0] prog_data,
    output logic prog_strobe,
    output logic [sop_pkg::ROW_W-1:0] mode_code,
    // data pins
    output logic [sop_pkg::DQ_W-1:0] dq_out,
    output logic [sop_pkg::DQ_W-1:0] dq_oe,
    output logic [sop_pkg::COL_W-1:0] column_addr_oe,
    // status
    output logic power_down,
    output logic suspended
);
    import sop_pkg::*;

    sop_cmd_e cmd;
    logic stop, cke_prev;
    logic [ROW_W-1:0] prog_row;
    logic [COL_W-1:0] prog_col;

    sop_decode u_dec (
        .clk(clk),
        .rst_n(rst_n),
        .pins(cmd_pins),
        .cmd(cmd),
        .stop(stop),
        .cke_prev(cke_prev)
    );

    sop_prog_addr u_padr (
        .clk(clk),
        .rst_n(rst_n),
        .enable(static_select),
        .prog(prog_pins),
        .addr(addr),
        .column_addr_pins(column_addr_pins),
        .row_q(prog_row),
        .col_q(prog_col)
    );

    sop_state_e st_q, st_d;
    logic [ROW_W-1:0] row_q, row_d, mode_q, mode_d;
    logic [COL_W-1:0] col_q, col_d;
    logic [BURST_W-1:0] left_q, left_d;
    logic [LAT_W-1:0] stop_cnt_q, stop_cnt_d;
    logic wide_q, wide_d;
    logic [1:0] mask_pipe_q, mask_pipe_d;
    logic [DQ_W-1:0] dq_out_q, dq_out_d, dq_oe_q, dq_oe_d;
    logic [DQ_LO_W-1:0] pdata_q, pdata_d;
    logic pstb_q, pstb_d;
    // address and width sampled with the command, used one edge later
    logic [ROW_W-1:0] cmd_addr_q, cmd_addr_d;
    logic cmd_wide_q, cmd_wide_d;
    // status outputs registered from the next state
    logic pdn_q, pdn_d, susp_q, susp_d;
    logic run;

    // internal clock runs when cke was sampled high last edge
    assign run = cke_prev;

    always_comb begin
        st_d = st_q;
        row_d = row_q;
        col_d = col_q;
        mode_d = mode_q;
        left_d = left_q;
        stop_cnt_d = stop_cnt_q;
        wide_d = wide_q;
        mask_pipe_d = {mask_pipe_q[0], out_mask};
        dq_out_d = dq_out_q;
        dq_oe_d = '0;
        pdata_d = pdata_q;
        pstb_d = 1'b0;
        cmd_addr_d = addr;
        cmd_wide_d = word_wide;
        if (static_select) begin
            st_d = SOP_ST_IDLE;
            row_d = prog_row;
            col_d = prog_col;
            // chip and output enable act as cycle strobes
            if (!prog_pins.ce_n && prog_pins.oe_n) begin
                pdata_d = dq_in;
                pstb_d = 1'b1;
            end else if (!prog_pins.ce_n && !prog_pins.oe_n) begin
                dq_out_d = {{(DQ_W-DQ_LO_W){1'b0}},
                    array_data[DQ_LO_W-1:0]};
                dq_oe_d = {{(DQ_W-DQ_LO_W){1'b0}},
                    {DQ_LO_W{1'b1}}};
            end
        end else begin
            unique case (st_q)
                SOP_ST_IDLE, SOP_ST_READ: begin
                    if (!cmd_pins.cke && cmd_pins.cs_n) begin
                        st_d = (st_q == SOP_ST_READ) ? SOP_ST_SUSP
                                                     : SOP_ST_PDN;
                    end
                    if (cmd == SOP_CMD_MRS && st_q == SOP_ST_IDLE)
                        mode_d = cmd_addr_q;
                    if (cmd == SOP_CMD_ACT)
                        row_d = cmd_addr_q;
                    if (cmd == SOP_CMD_RD) begin
                        col_d = cmd_addr_q[COL_W-1:0];
                        wide_d = cmd_wide_q;
                        // counts down to zero, the zero beat is the last
                        left_d = BURST_W'(BURST_LEN - 1);
                        stop_cnt_d = '0;
                        st_d = SOP_ST_READ;
                    end else if (stop && st_q == SOP_ST_READ)
                        stop_cnt_d = CAS_LAT_RST;
                    if (st_q == SOP_ST_READ && cmd != SOP_CMD_RD) begin
                        if (stop_cnt_q == LAT_W'(1) || left_q == '0) begin
                            st_d = SOP_ST_IDLE;
                            stop_cnt_d = '0;
                        end else begin
                            left_d = left_q - BURST_W'(1);
                            if (stop_cnt_q != '0)
                                stop_cnt_d = stop_cnt_q - LAT_W'(1);
                            col_d = col_q + COL_W'(1);
                        end
                        dq_out_d = wide_q ? array_data
                            : {{(DQ_W-DQ_LO_W){1'b0}},
                               array_data[DQ_LO_W-1:0]};
                        if (!mask_pipe_q[1])
                            dq_oe_d = wide_q ? {DQ_W{1'b1}}
                                : {{(DQ_W-DQ_LO_W){1'b0}},
                                   {DQ_LO_W{1'b1}}};
                    end
                end
                SOP_ST_SUSP: begin
                    dq_oe_d = dq_oe_q; // frozen
                    if (cmd_pins.cke)
                        st_d = SOP_ST_READ;
                end
                SOP_ST_PDN: begin
                    if (cmd_pins.cke)
                        st_d = SOP_ST_IDLE;
                end
            endcase
        end
        if (!run && st_q != SOP_ST_SUSP)
            dq_oe_d = dq_oe_q;
        pdn_d = (st_d == SOP_ST_PDN);
        susp_d = (st_d == SOP_ST_SUSP);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_q <= SOP_ST_IDLE;
            row_q <= '0;
            col_q <= '0;
            mode_q <= '0;
            left_q <= '0;
            stop_cnt_q <= '0;
            wide_q <= 1'b0;
            mask_pipe_q <= '0;
            dq_out_q <= DATA_RST;
            dq_oe_q <= '0;
            pdata_q <= '0;
            pstb_q <= 1'b0;
            cmd_addr_q <= '0;
            cmd_wide_q <= 1'b0;
            pdn_q <= 1'b0;
            susp_q <= 1'b0;
        end else begin
            st_q <= st_d;
            row_q <= row_d;
            col_q <= col_d;
            mode_q <= mode_d;
            left_q <= left_d;
            stop_cnt_q <= stop_cnt_d;
            wide_q <= wide_d;
            mask_pipe_q <= mask_pipe_d;
            dq_out_q <= dq_out_d;
            dq_oe_q <= dq_oe_d;
            pdata_q <= pdata_d;
            pstb_q <= pstb_d;
            cmd_addr_q <= cmd_addr_d;
            cmd_wide_q <= cmd_wide_d;
            pdn_q <= pdn_d;
            susp_q <= susp_d;
        end
    end

    // column pins are inputs only, never driven
    logic [COL_W-1:0] col_oe_q;
    always_ff @(posedge clk) begin
        col_oe_q <= '0;
    end

    assign row_addr = row_q;
    assign col_addr = col_q;
    assign mode_code = mode_q;
    assign prog_data = pdata_q;
    assign prog_strobe = pstb_q;
    assign dq_out = dq_out_q;
    assign dq_oe = dq_oe_q;
    assign column_addr_oe = col_oe_q;
    assign power_down = pdn_q;
    assign suspended = susp_q;

    sequence s_pdn_cycle;
        st_q == SOP_ST_PDN ##1 st_q == SOP_ST_IDLE;
    endsequence

    a_sync_idle: assert property (@(posedge clk) disable iff (!rst_n)
        static_select |=> st_q == SOP_ST_IDLE)
        else $error("prog mode left state busy");
    a_rd_start: assert property (@(posedge clk) disable iff (!rst_n)
        !static_select && cmd == SOP_CMD_RD && st_q != SOP_ST_SUSP
        && st_q != SOP_ST_PDN |=> st_q == SOP_ST_READ && wide_q ==
        $past(word_wide, 2)) else $error("read not started");
    a_act_row: assert property (@(posedge clk) disable iff (!rst_n)
        !static_select && cmd == SOP_CMD_ACT && st_q == SOP_ST_IDLE
        |=> row_q == $past(addr, 2)) else $error("row not taken");
    a_mask_hiz: assert property (@(posedge clk) disable iff (!rst_n)
        mask_pipe_q[1] && st_q == SOP_ST_READ && run && !static_select
        |=> dq_oe_q == '0) else $error("masked output driven");
    a_pdn_entry: assert property (@(posedge clk) disable iff (!rst_n)
        !static_select && st_q == SOP_ST_IDLE && !cmd_pins.cke
        && cmd_pins.cs_n |=> power_down)
        else $error("no power down");
    a_pdn_row: assert property (@(posedge clk) disable iff (!rst_n)
        s_pdn_cycle |-> row_q == $past(row_q))
        else $error("row lost over power down");
    a_x16_hiz: assert property (@(posedge clk) disable iff (!rst_n)
        !wide_q |-> dq_oe_q[DQ_W-1:DQ_LO_W] == '0)
        else $error("upper lanes driven in x16");
    a_colpin_in: assert property (@(posedge clk) disable iff (!rst_n)
        column_addr_oe == '0) else $error("column pins driven");
    a_stop_lat: assert property (@(posedge clk) disable iff (!rst_n)
        stop_cnt_q == LAT_W'(1) && st_q == SOP_ST_READ && cmd !=
        SOP_CMD_RD && !static_select && !(!cmd_pins.cke &&
        cmd_pins.cs_n) |=> st_q == SOP_ST_IDLE)
        else $error("stop not honoured");
    a_rd_col: assert property (
        @(posedge clk) disable iff (!rst_n)
        !static_select && cmd == SOP_CMD_RD && st_q != SOP_ST_SUSP
        && st_q != SOP_ST_PDN |=> col_q == COL_W'($past(addr, 2)))
        else $error("read column wrong");
    a_mrs_code: assert property (
        @(posedge clk) disable iff (!rst_n)
        !static_select && cmd == SOP_CMD_MRS && st_q == SOP_ST_IDLE
        |=> mode_q == $past(addr, 2)) else $error("mode code lost");
    a_pdn_exit: assert property (
        @(posedge clk) disable iff (!rst_n)
        !static_select && st_q == SOP_ST_PDN && cmd_pins.cke
        |=> st_q == SOP_ST_IDLE && !power_down)
        else $error("power down not left");

    // a burst beat that is neither the last one nor the end of a stop
    sequence s_mid_beat;
        st_q == SOP_ST_READ && cmd != SOP_CMD_RD && left_q != '0
        && stop_cnt_q != LAT_W'(1);
    endsequence

    a_susp_entry: assert property (
        @(posedge clk) disable iff (!rst_n)
        !static_select && !cmd_pins.cke && cmd_pins.cs_n ##0 s_mid_beat
        |=> suspended) else $error("no clock suspend");
    a_susp_hold: assert property (
        @(posedge clk) disable iff (!rst_n)
        !static_select && st_q == SOP_ST_SUSP && !cmd_pins.cke
        |=> $stable(dq_oe_q) && $stable(col_q) && $stable(left_q))
        else $error("suspended burst moved");
    a_x32_beat: assert property (
        @(posedge clk) disable iff (!rst_n)
        !static_select && st_q == SOP_ST_READ && cmd != SOP_CMD_RD
        && run && wide_q && !mask_pipe_q[1] |=> dq_oe_q == '1)
        else $error("x32 beat not driven");
    a_prog_strobe: assert property (
        @(posedge clk) disable iff (!rst_n)
        static_select && !prog_pins.ce_n && prog_pins.oe_n
        |=> prog_strobe && prog_data == $past(dq_in))
        else $error("program cycle missed");
    a_prog_read: assert property (
        @(posedge clk) disable iff (!rst_n)
        static_select && !prog_pins.ce_n && !prog_pins.oe_n
        |=> dq_oe_q == {{(DQ_W-DQ_LO_W){1'b0}}, {DQ_LO_W{1'b1}}})
        else $error("verify read not driven");
endmodule // sop_top

// file: sim/sop_ctrl_model.sv
// memory controller model driving the synchronous command pins
// assumes calls start at a falling clk edge; device samples on rising
`timescale 1ns/1ps
module sop_ctrl_model
    import sop_pkg::*;
(
    // clock
    input wire logic clk,
    // pins towards the device
    output sop_pkg::sop_cmd_s cmd_pins,
    output logic [sop_pkg::ROW_W-1:0] addr,
    output logic word_wide,
    output logic out_mask
);
    initial begin
        cmd_pins = 5'h1f;
        addr = 13'h0000;
        word_wide = 1'b0;
        out_mask = 1'b0;
    end

    // c is {cs_n, ras_n, cas_n, mode_strobe_n}, held for one edge
    task automatic cmd(input logic [3:0] c, input logic [ROW_W-1:0] a);
        cmd_pins[3:0] = c;
        addr = a;
        @(negedge clk);
        cmd_pins[3:0] = 4'hf;
        // released bus must not keep showing the old address
        addr = ~a;
        @(negedge clk);
    endtask

    task automatic mode_set(input logic [ROW_W-1:0] code);
        cmd(4'h0, code);
        repeat (MRS_BLOCK) @(negedge clk);
    endtask

    task automatic set_cke(input logic v);
        cmd_pins.cke = v;
    endtask
endmodule // sop_ctrl_model

// file: sim/testbench.sv
// self-checking bench for the otp pin-mode and command logic
// assumes sop_ctrl_model owns the command pins; bench drives the rest
`timescale 1ns/1ps
module testbench;
    import sop_pkg::*;
    logic clk, rst_n, static_select, word_wide, out_mask;
    sop_cmd_s cmd_pins;
    sop_prog_s prog_pins;
    logic [ROW_W-1:0] addr, row_addr, mode_code, r, c;
    logic [COL_W-1:0] column_addr_pins, col_addr, column_addr_oe;
    logic [DQ_LO_W-1:0] dq_in, prog_data;
    logic [DQ_W-1:0] array_data, dq_out, dq_oe;
    logic prog_strobe, power_down, suspended;
    logic [3:0] nops[6] = '{4'h7, 4'h1, 4'h4, 4'h6, 4'h2, 4'hb};
    logic [3:0] stops[2] = '{4'h6, 4'h2};
    int error_cnt, tests_run;

    sop_ctrl_model ctrl (.clk(clk), .cmd_pins(cmd_pins), .addr(addr),
        .word_wide(word_wide), .out_mask(out_mask));

    sop_top #(.BURST_LEN(16)) uut (.clk(clk), .rst_n(rst_n),
        .static_select(static_select), .word_wide(word_wide),
        .cmd_pins(cmd_pins), .out_mask(out_mask), .addr(addr),
        .prog_pins(prog_pins), .column_addr_pins(column_addr_pins),
        .dq_in(dq_in), .array_data(array_data), .row_addr(row_addr),
        .col_addr(col_addr), .prog_data(prog_data),
        .prog_strobe(prog_strobe), .mode_code(mode_code),
        .dq_out(dq_out), .dq_oe(dq_oe), .column_addr_oe(column_addr_oe),
        .power_down(power_down), .suspended(suspended));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // array content changes every cycle so stale beats cannot hide
    always @(negedge clk) array_data <= $urandom;

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string m);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask

    function automatic logic [31:0] oe_exp(input logic ww);
        return ww ? 32'hffff_ffff : 32'h0000_ffff;
    endfunction

    // array word as it should appear on the data pins for one width
    function automatic logic [31:0] data_exp(input logic ww,
                                             input logic [31:0] a);
        return ww ? a : {16'h0000, a[15:0]};
    endfunction

    task automatic finish_test();
        $display("errors %0d checks %0d", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic wait_idle();
        for (int i = 0; i < 60 && dq_oe !== 32'h0; i++) begin
            cyc(1);
        end
        if (dq_oe !== 32'h0) begin
            chk(32'h1, 32'h0, "burst never ended");
            finish_test();
        end
    endtask

    task automatic rd(input logic ww);
        c = ROW_W'($urandom_range(0, 511));
        ctrl.word_wide = ww;
        ctrl.cmd(4'h5, c);
        // width is taken with the command only
        ctrl.word_wide = ~ww;
        chk(32'(col_addr), 32'(c[COL_W-1:0]), "read column");
        cyc(2);
        chk(dq_oe, oe_exp(ww), "burst width");
        chk(dq_out, data_exp(ww, array_data), "burst data");
        ctrl.out_mask = 1'b1;
        cyc(4);
        chk(dq_oe, 32'h0, "mask floats");
        ctrl.out_mask = 1'b0;
        cyc(3);
        chk(dq_oe, oe_exp(ww), "unmask drives");
        wait_idle();
    endtask

    initial begin
        void'($urandom(32'h79a8));
        error_cnt = 0;
        tests_run = 0;
        rst_n = 1'b0;
        static_select = 1'b0;
        prog_pins = 5'h0f;
        column_addr_pins = 9'h000;
        dq_in = 16'h0000;
        array_data = 32'h0;
        cyc(20);
        rst_n = 1'b1;
        chk(dq_oe, 32'h0, "reset oe");
        chk({power_down, suspended}, 32'h0, "reset state");
        r = ROW_W'($urandom);
        ctrl.mode_set(r);
        chk(mode_code, r, "mode code");
        r = ROW_W'($urandom);
        ctrl.cmd(4'h3, r);
        chk(row_addr, r, "row activate");
        foreach (nops[i]) begin
            ctrl.cmd(nops[i], ~r);
            chk(row_addr, r, "no-op row");
            chk(dq_oe, 32'h0, "no-op oe");
        end
        for (int k = 0; k < 4; k++) begin
            rd(k < 2 ? k[0] : 1'($urandom_range(0, 1)));
        end
        foreach (stops[i]) begin
            ctrl.word_wide = 1'b1;
            ctrl.cmd(4'h5, 13'h0000);
            ctrl.cmd(stops[i], 13'h0000);
            chk(dq_oe, 32'hffff_ffff, "stop too early");
            cyc(8);
            chk(dq_oe, 32'h0, "stop ignored");
            wait_idle();
        end
        ctrl.word_wide = 1'b0;
        ctrl.cmd(4'h5, 13'h000f);
        cyc(2);
        ctrl.set_cke(1'b0);
        cyc(3);
        chk(suspended, 1'b1, "suspend entry");
        chk(dq_oe, oe_exp(1'b0), "suspend holds");
        ctrl.set_cke(1'b1);
        cyc(3);
        chk(suspended, 1'b0, "suspend exit");
        wait_idle();
        ctrl.set_cke(1'b0);
        cyc(3);
        chk(power_down, 1'b1, "power down");
        ctrl.set_cke(1'b1);
        cyc(3);
        chk(power_down, 1'b0, "power up");
        chk(row_addr, r, "row kept");
        static_select = 1'b1;
        ctrl.word_wide = 1'b0;
        ctrl.addr = ROW_W'($urandom);
        column_addr_pins = COL_W'($urandom);
        cyc(3);
        chk(row_addr, ctrl.addr, "flat row");
        chk(col_addr, column_addr_pins, "flat column");
        prog_pins.addr_mux_select = 1'b1;
        c = ROW_W'($urandom);
        r = ROW_W'($urandom);
        ctrl.addr = c;
        prog_pins.ras_n = 1'b0;
        cyc(2);
        prog_pins.ras_n = 1'b1;
        cyc(2);
        ctrl.addr = r;
        column_addr_pins = ~r[COL_W-1:0];
        prog_pins.cas_n = 1'b0;
        cyc(2);
        prog_pins.cas_n = 1'b1;
        cyc(2);
        ctrl.addr = ~r;
        cyc(3);
        chk(row_addr, c, "muxed row");
        chk(col_addr, r[COL_W-1:0], "muxed column");
        dq_in = DQ_LO_W'($urandom);
        prog_pins.ce_n = 1'b0;
        cyc(2);
        chk(prog_strobe, 1'b1, "program strobe");
        chk(prog_data, dq_in, "program data");
        prog_pins.ce_n = 1'b1;
        cyc(2);
        chk(prog_strobe, 1'b0, "strobe end");
        chk(column_addr_oe, 32'h0, "column pins");
        prog_pins.ce_n = 1'b0;
        prog_pins.oe_n = 1'b0;
        cyc(1);
        chk(dq_oe, oe_exp(1'b0), "verify drives");
        chk(dq_out, data_exp(1'b0, array_data), "verify data");
        prog_pins.ce_n = 1'b1;
        prog_pins.oe_n = 1'b1;
        cyc(2);
        chk(dq_oe, 32'h0, "verify release");
        finish_test();
    end
endmodule // testbench
